/* File: hdl/msrh_fill.sv */
// Substitutes fixed patterns for unused and reserved registers on reads.
// Assumes the map reports kind and format of the addressed register.
`timescale 1ns/1ps
`default_nettype none
`include "msrh_map.svh"
module msrh_fill (
  input wire logic i_unmapped,
  input wire logic i_reserved,
  input wire msrh_pkg::msrh_fmt_e i_fmt,
  input wire logic i_low_word,
  input wire logic [15:0] i_rdata,
  output logic [15:0] o_word
);
  always_comb begin
    o_word = i_rdata;
    if (i_unmapped) begin
      o_word = `MSRH_FILL_UNUSED;
    end else if (i_reserved) begin
      case (i_fmt)
        msrh_pkg::MSRH_FMT_U16: o_word = `MSRH_FILL_U16;
        msrh_pkg::MSRH_FMT_F32: o_word = i_low_word ? `MSRH_FILL_F32_LO : `MSRH_FILL_F32_HI;
        default: o_word = `MSRH_FILL_S16;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: hdl/msrh_req_handler.sv */
// Slave request handler: takes one framed request, checks it, runs it
// against the register map and streams the answer frame.
// Assumes frames come without checksum and the map answers combinationally.
// What this block does
// - Serve read holding, write one holding and write many holding codes
// - Report identity code served on serial links only
// - Serve read of scattered holding registers in one request
// - Input register read, coil write codes are master-only, refused here
// - Registers are 16-bit words; read-only ones refuse writes
// - Coils and input bits are not served in the slave role
// - Each word goes out high byte first
// - Multi-word values go out high word first
// - Float word-order choice exists only for the master role
// - Unit identifier zero is a broadcast
// - Only write-many is acted on when broadcast
// - On a single-slave serial link, unit 248 addresses this device
// - Unknown or unsupported code answers exception 01
// - Address out of range or wrong for code answers exception 02
// - Address blocked by security answers exception 02
// - Value not allowed for the register answers exception 03
// - Access cutting through a multi-word value answers exception 03, except in scattered reads
// - Reading an unused register returns 0x8000
// - Reading a reserved register returns its format's fill pattern
// - Write to unmapped address stores nothing and sends nothing
// - Write to read-only register answers exception 3
// - Writes refused until security allows them
// - Own unit identifier is valid only from 0 to 247
`timescale 1ns/1ps
`default_nettype none
`include "msrh_map.svh"
module msrh_req_handler #(
  parameter int RX_DEPTH = `MSRH_RX_DEPTH,
  parameter logic [7:0] ID_TAG = 8'h5a // Arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_is_serial,
  input wire logic i_single_slave,
  input wire logic [7:0] i_unit_id,
  input wire logic i_wr_allow,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  output logic o_rx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  output logic o_map_rd,
  output logic o_map_wr,
  output logic [15:0] o_map_addr,
  output logic [15:0] o_map_wdata,
  input wire logic [15:0] i_map_rdata,
  input wire logic i_map_in_range,
  input wire logic i_map_unmapped,
  input wire logic i_map_reserved,
  input wire msrh_pkg::msrh_fmt_e i_map_fmt,
  input wire logic i_map_ro,
  input wire logic i_map_locked,
  input wire logic i_map_mw_inner,
  input wire logic i_map_mw_open,
  input wire logic i_map_val_ok,
  output logic o_busy
);
  // Depth must stay at or below 511 so lengths fit nine bits
  localparam int IW = $clog2(RX_DEPTH);
  logic rst_b;
  logic [7:0] rx_buf_q [RX_DEPTH];
  logic [8:0] rx_len_q;
  logic rx_new_q;
  logic [8:0] wr_ptr;
  logic rx_acc;
  msrh_pkg::msrh_state_e st_q;
  logic [7:0] exc_q;
  logic bcast_q;
  logic [6:0] idx_q;
  logic [6:0] qty_q;
  logic [8:0] tx_idx_q;
  logic [8:0] tx_len_q;
  logic [15:0] word_q;
  logic have_word_q;
  logic [15:0] fill_word;
  logic [7:0] unit;
  logic [7:0] fc;
  logic [15:0] q16;
  logic [7:0] bc_sc;
  logic [7:0] bc_wm;
  logic is_wr;
  logic is_rd;
  logic own_ok;
  logic d_ignore;
  logic [7:0] d_exc;
  logic [6:0] d_qty;
  logic c_drop;
  logic [7:0] c_exc;
  logic last_item;
  logic data_pos;
  logic [8:0] dw;
  logic [7:0] tx_byte;

  msrh_rst_sync u_rst (
    .i_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .o_rst_b(rst_b)
  );

  function automatic logic [7:0] rxb(input logic [8:0] p);
    rxb = rx_buf_q[p[IW-1:0]];
  endfunction

  function automatic logic [15:0] rxw(input logic [8:0] p);
    rxw = {rxb(p), rxb(p + 9'h001)};
  endfunction

  function automatic logic [15:0] addr_of(input logic [6:0] i);
    if (fc == `MSRH_FC_RD_SCATTER) begin
      addr_of = rxw(`MSRH_LEN_RD_HDR + {1'b0, i, 1'b0});
    end else begin
      addr_of = rxw(9'h002) + {9'h000, i};
    end
  endfunction

  function automatic logic [15:0] wval(input logic [6:0] i);
    if (fc == `MSRH_FC_WR_ONE) begin
      wval = rxw(`MSRH_IDX_QTY);
    end else begin
      wval = rxw(`MSRH_LEN_WM_HDR + {1'b0, i, 1'b0});
    end
  endfunction

  assign unit = rx_buf_q[0];
  assign fc = rx_buf_q[1];
  assign q16 = rxw(`MSRH_IDX_QTY);
  assign bc_sc = rxb(`MSRH_IDX_BC_SC);
  assign bc_wm = rxb(`MSRH_IDX_BC_WM);
  assign is_wr = (fc == `MSRH_FC_WR_ONE) || (fc == `MSRH_FC_WR_MULTI);
  assign is_rd = (fc == `MSRH_FC_RD_HOLD) || (fc == `MSRH_FC_RD_SCATTER);
  assign rx_acc = o_rx_ready && i_rx_valid;
  assign wr_ptr = rx_new_q ? 9'h000 : rx_len_q;
  assign last_item = idx_q == (qty_q - 7'h01);
  assign data_pos = is_rd && (exc_q == `MSRH_EXC_NONE) && (tx_idx_q >= `MSRH_LEN_RD_HDR);
  assign dw = tx_idx_q - `MSRH_LEN_RD_HDR;

  // Frame capture; an over-long frame saturates and later fails length checks
  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_len_q <= 9'h000;
      rx_new_q <= 1'b1;
    end else if (rx_acc) begin
      rx_new_q <= i_rx_last;
      if (wr_ptr != 9'(RX_DEPTH)) begin
        rx_len_q <= wr_ptr + 9'h001;
      end else begin
        rx_len_q <= wr_ptr;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rx_acc && (wr_ptr != 9'(RX_DEPTH))) begin
      rx_buf_q[wr_ptr[IW-1:0]] <= i_rx_data;
    end
  end

  // Frame-level decode
  always_comb begin
    d_ignore = 1'b0;
    d_exc = `MSRH_EXC_NONE;
    d_qty = 7'h01;
    own_ok = (i_unit_id <= `MSRH_UNIT_MAX) && (unit == i_unit_id);
    if (rx_len_q < 9'h002) begin
      d_ignore = 1'b1;
    end else if (i_is_serial && !own_ok && (unit != `MSRH_UNIT_BCAST) &&
                 !((unit == `MSRH_UNIT_SOLO) && i_single_slave)) begin
      d_ignore = 1'b1;
    end else if ((unit == `MSRH_UNIT_BCAST) && (fc != `MSRH_FC_WR_MULTI)) begin
      d_ignore = 1'b1;
    end else begin
      case (fc)
        `MSRH_FC_RD_HOLD: begin
          d_qty = q16[6:0];
          if ((rx_len_q != `MSRH_LEN_FIXED) || (q16 == 16'h0000) || (q16 > `MSRH_RD_MAX)) begin
            d_exc = `MSRH_EXC_VALUE;
          end
        end
        `MSRH_FC_WR_ONE: begin
          if (rx_len_q != `MSRH_LEN_FIXED) begin
            d_exc = `MSRH_EXC_VALUE;
          end
        end
        `MSRH_FC_WR_MULTI: begin
          d_qty = q16[6:0];
          if ((rx_len_q != (`MSRH_LEN_WM_HDR + {1'b0, bc_wm})) || (q16 == 16'h0000) ||
              (q16 > `MSRH_WR_MAX) || ({8'h00, bc_wm} != {q16[14:0], 1'b0})) begin
            d_exc = `MSRH_EXC_VALUE;
          end
        end
        `MSRH_FC_REPORT_ID: begin
          if (!i_is_serial) begin
            d_exc = `MSRH_EXC_FUNC;
          end else if (rx_len_q != `MSRH_LEN_ID_REQ) begin
            d_exc = `MSRH_EXC_VALUE;
          end
        end
        `MSRH_FC_RD_SCATTER: begin
          d_qty = bc_sc[7:1];
          if ((rx_len_q != (`MSRH_LEN_RD_HDR + {1'b0, bc_sc})) || bc_sc[0] ||
              (bc_sc == 8'h00) || ({9'h000, bc_sc[7:1]} > `MSRH_RD_MAX)) begin
            d_exc = `MSRH_EXC_VALUE;
          end
        end
        default: d_exc = `MSRH_EXC_FUNC;
      endcase
    end
  end

  // Per-item checks; first failing item decides the answer
  always_comb begin
    c_drop = 1'b0;
    c_exc = `MSRH_EXC_NONE;
    if (!i_map_in_range) begin
      c_exc = `MSRH_EXC_ADDR;
    end else if (is_wr && i_map_unmapped) begin
      c_drop = 1'b1;
    end else if (i_map_locked || (is_wr && !i_wr_allow)) begin
      c_exc = `MSRH_EXC_ADDR;
    end else if (is_wr && i_map_ro) begin
      c_exc = `MSRH_EXC_VALUE;
    end else if ((fc != `MSRH_FC_RD_SCATTER) &&
                 (((idx_q == 7'h00) && i_map_mw_inner) || (last_item && i_map_mw_open))) begin
      c_exc = `MSRH_EXC_VALUE;
    end else if (is_wr && !i_map_val_ok) begin
      c_exc = `MSRH_EXC_VALUE;
    end
  end

  msrh_fill u_fill (
    .i_unmapped(i_map_unmapped),
    .i_reserved(i_map_reserved),
    .i_fmt(i_map_fmt),
    .i_low_word(i_map_mw_inner),
    .i_rdata(i_map_rdata),
    .o_word(fill_word)
  );

  // Answer byte for the current position
  always_comb begin
    tx_byte = word_q[7:0];
    if (exc_q != `MSRH_EXC_NONE) begin
      case (tx_idx_q)
        9'h000: tx_byte = unit;
        9'h001: tx_byte = fc | `MSRH_FC_EXC_FLAG;
        default: tx_byte = exc_q;
      endcase
    end else if (fc == `MSRH_FC_REPORT_ID) begin
      case (tx_idx_q)
        9'h000: tx_byte = unit;
        9'h001: tx_byte = fc;
        9'h002: tx_byte = `MSRH_ID_BYTES;
        9'h003: tx_byte = ID_TAG;
        default: tx_byte = `MSRH_RUN_ON;
      endcase
    end else if (is_wr) begin
      tx_byte = rxb(tx_idx_q);
    end else if (tx_idx_q == 9'h000) begin
      tx_byte = unit;
    end else if (tx_idx_q == 9'h001) begin
      tx_byte = fc;
    end else if (tx_idx_q == 9'h002) begin
      tx_byte = {qty_q, 1'b0};
    end else if (tx_idx_q[0]) begin
      tx_byte = word_q[15:8];
    end
  end

  // Slave role keeps high word first; a float word swap would belong to the master side
  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= msrh_pkg::ST_RX;
      exc_q <= `MSRH_EXC_NONE;
      bcast_q <= 1'b0;
      idx_q <= 7'h00;
      qty_q <= 7'h00;
      tx_idx_q <= 9'h000;
      tx_len_q <= 9'h000;
      word_q <= 16'h0000;
      have_word_q <= 1'b0;
      o_rx_ready <= 1'b0;
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_last <= 1'b0;
      o_map_rd <= 1'b0;
      o_map_wr <= 1'b0;
      o_map_addr <= 16'h0000;
      o_map_wdata <= 16'h0000;
      o_busy <= 1'b0;
    end else begin
      o_map_rd <= 1'b0;
      o_map_wr <= 1'b0;
      case (st_q)
        msrh_pkg::ST_RX: begin
          o_rx_ready <= 1'b1;
          o_busy <= 1'b0;
          if (rx_acc && i_rx_last) begin
            o_rx_ready <= 1'b0;
            o_busy <= 1'b1;
            st_q <= msrh_pkg::ST_DEC;
          end
        end
        msrh_pkg::ST_DEC: begin
          bcast_q <= unit == `MSRH_UNIT_BCAST;
          qty_q <= d_qty;
          idx_q <= 7'h00;
          tx_idx_q <= 9'h000;
          have_word_q <= 1'b0;
          exc_q <= d_exc;
          if (d_ignore || ((unit == `MSRH_UNIT_BCAST) && (d_exc != `MSRH_EXC_NONE))) begin
            st_q <= msrh_pkg::ST_RX;
          end else if (d_exc != `MSRH_EXC_NONE) begin
            tx_len_q <= `MSRH_LEN_EXC;
            st_q <= msrh_pkg::ST_SEND;
          end else if (fc == `MSRH_FC_REPORT_ID) begin
            tx_len_q <= `MSRH_LEN_ID;
            st_q <= msrh_pkg::ST_SEND;
          end else begin
            st_q <= msrh_pkg::ST_CHK;
          end
        end
        msrh_pkg::ST_CHK: begin
          o_map_addr <= addr_of(idx_q);
          o_map_wdata <= wval(idx_q);
          st_q <= msrh_pkg::ST_CHKW;
        end
        msrh_pkg::ST_CHKW: begin
          if (c_drop) begin
            st_q <= msrh_pkg::ST_RX;
          end else if (c_exc != `MSRH_EXC_NONE) begin
            exc_q <= c_exc;
            tx_len_q <= `MSRH_LEN_EXC;
            st_q <= bcast_q ? msrh_pkg::ST_RX : msrh_pkg::ST_SEND;
          end else if (!last_item) begin
            idx_q <= idx_q + 7'h01;
            st_q <= msrh_pkg::ST_CHK;
          end else if (is_wr) begin
            idx_q <= 7'h00;
            st_q <= msrh_pkg::ST_WR;
          end else begin
            tx_len_q <= `MSRH_LEN_RD_HDR + {1'b0, qty_q, 1'b0};
            st_q <= msrh_pkg::ST_SEND;
          end
        end
        msrh_pkg::ST_WR: begin
          // Writes start only after every item passed, so a refused request leaves the map untouched
          o_map_addr <= addr_of(idx_q);
          o_map_wdata <= wval(idx_q);
          o_map_wr <= 1'b1;
          idx_q <= idx_q + 7'h01;
          if (last_item) begin
            tx_len_q <= `MSRH_LEN_ECHO;
            st_q <= bcast_q ? msrh_pkg::ST_RX : msrh_pkg::ST_SEND;
          end
        end
        msrh_pkg::ST_SEND: begin
          if (o_tx_valid) begin
            if (i_tx_ready) begin
              o_tx_valid <= 1'b0;
              tx_idx_q <= tx_idx_q + 9'h001;
              if (data_pos && !tx_idx_q[0]) begin
                have_word_q <= 1'b0;
              end
              if (o_tx_last) begin
                st_q <= msrh_pkg::ST_RX;
              end
            end
          end else if (data_pos && !have_word_q) begin
            o_map_addr <= addr_of(dw[7:1]);
            o_map_rd <= 1'b1;
            st_q <= msrh_pkg::ST_FET;
          end else begin
            o_tx_data <= tx_byte;
            o_tx_valid <= 1'b1;
            o_tx_last <= tx_idx_q == (tx_len_q - 9'h001);
          end
        end
        msrh_pkg::ST_FET: begin
          word_q <= fill_word;
          have_word_q <= 1'b1;
          st_q <= msrh_pkg::ST_SEND;
        end
        default: st_q <= msrh_pkg::ST_RX;
      endcase
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_b);

  property p_bcast_mute;
    bcast_q && (st_q inside {msrh_pkg::ST_CHK, msrh_pkg::ST_CHKW, msrh_pkg::ST_WR,
                             msrh_pkg::ST_SEND}) |-> !o_tx_valid;
  endproperty
  a_bcast_mute: assert property (p_bcast_mute) else $error("broadcast answered");
  property p_bcast_only_multi;
    o_map_wr && bcast_q |-> fc == `MSRH_FC_WR_MULTI;
  endproperty
  a_bcast_only_multi: assert property (p_bcast_only_multi) else $error("bad broadcast write");
  property p_master_only;
    st_q == msrh_pkg::ST_DEC && !d_ignore && unit != `MSRH_UNIT_BCAST &&
    fc == `MSRH_FC_RD_INPUT |=> exc_q == `MSRH_EXC_FUNC && st_q == msrh_pkg::ST_SEND;
  endproperty
  a_master_only: assert property (p_master_only) else $error("master-only code served");
  property p_id_serial;
    st_q == msrh_pkg::ST_DEC && !d_ignore && !i_is_serial && fc == `MSRH_FC_REPORT_ID
    |=> exc_q == `MSRH_EXC_FUNC;
  endproperty
  a_id_serial: assert property (p_id_serial) else $error("identity over network");
  property p_foreign_unit;
    st_q == msrh_pkg::ST_DEC && i_is_serial && rx_len_q >= 9'h002 && unit != i_unit_id &&
    unit != `MSRH_UNIT_BCAST && unit != `MSRH_UNIT_SOLO |=> st_q == msrh_pkg::ST_RX;
  endproperty
  a_foreign_unit: assert property (p_foreign_unit) else $error("foreign unit served");
  property p_solo;
    st_q == msrh_pkg::ST_DEC && i_is_serial && i_single_slave && rx_len_q >= 9'h002 &&
    unit == `MSRH_UNIT_SOLO && fc == `MSRH_FC_RD_HOLD |=> st_q != msrh_pkg::ST_RX;
  endproperty
  a_solo: assert property (p_solo) else $error("unit 248 ignored");
  property p_unmapped_wr;
    st_q == msrh_pkg::ST_CHKW && c_drop |=> st_q == msrh_pkg::ST_RX ##1 !o_map_wr && !o_tx_valid;
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write acted");
  property p_ro_wr;
    st_q == msrh_pkg::ST_CHKW && is_wr && i_map_in_range && !i_map_unmapped && !i_map_locked &&
    i_wr_allow && i_map_ro |=> exc_q == `MSRH_EXC_VALUE;
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("read-only write accepted");
  property p_locked;
    st_q == msrh_pkg::ST_CHKW && i_map_in_range && i_map_locked && !(is_wr && i_map_unmapped)
    |=> exc_q == `MSRH_EXC_ADDR;
  endproperty
  a_locked: assert property (p_locked) else $error("locked address served");
  property p_unused_fill;
    st_q == msrh_pkg::ST_FET && i_map_unmapped |=> word_q == `MSRH_FILL_UNUSED;
  endproperty
  a_unused_fill: assert property (p_unused_fill) else $error("unused fill wrong");
  property p_u16_fill;
    st_q == msrh_pkg::ST_FET && !i_map_unmapped && i_map_reserved &&
    i_map_fmt == msrh_pkg::MSRH_FMT_U16 |=> word_q == `MSRH_FILL_U16;
  endproperty
  a_u16_fill: assert property (p_u16_fill) else $error("reserved fill wrong");
  property p_hi_first;
    o_tx_valid && data_pos && tx_idx_q[0] |-> o_tx_data == word_q[15:8] && have_word_q;
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("low byte first");

  c_rd_done: cover property (o_tx_valid && o_tx_last && i_tx_ready && is_rd && exc_q == 8'h00);
  c_bcast_wr: cover property (o_map_wr && bcast_q);
  c_exc_sent: cover property (o_tx_valid && o_tx_last && exc_q != `MSRH_EXC_NONE);
endmodule
`default_nettype wire

/* File: hdl/msrh_rst_sync.sv */
// Reset release synchroniser.
// Assumes an active-low asynchronous reset and a free-running clock.
`timescale 1ns/1ps
`default_nettype none
module msrh_rst_sync (
  input wire logic i_clk,
  input wire logic i_rst_b,
  output logic o_rst_b
);
  logic meta_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      o_rst_b <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      o_rst_b <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: inc/msrh_map.svh */
// Constants for the request handler: function codes, exception codes,
// unit identifiers, fill patterns and frame lengths.
// Assumes frames arrive without checksum or transport header.
`ifndef MSRH_MAP_SVH
`define MSRH_MAP_SVH
`define MSRH_FC_RD_HOLD 8'h03
`define MSRH_FC_WR_ONE 8'h06
`define MSRH_FC_WR_MULTI 8'h10
`define MSRH_FC_REPORT_ID 8'h11
`define MSRH_FC_RD_SCATTER 8'h64
`define MSRH_FC_RD_INPUT 8'h04
`define MSRH_FC_EXC_FLAG 8'h80
`define MSRH_EXC_NONE 8'h00
`define MSRH_EXC_FUNC 8'h01
`define MSRH_EXC_ADDR 8'h02
`define MSRH_EXC_VALUE 8'h03
`define MSRH_UNIT_BCAST 8'h00
`define MSRH_UNIT_SOLO 8'hf8
`define MSRH_UNIT_MAX 8'hf7
`define MSRH_FILL_UNUSED 16'h8000
`define MSRH_FILL_S16 16'h8000
`define MSRH_FILL_U16 16'hffff
`define MSRH_FILL_F32_HI 16'hffc0
`define MSRH_FILL_F32_LO 16'h0000
`define MSRH_RD_MAX 16'h007d
`define MSRH_WR_MAX 16'h007b
`define MSRH_RUN_ON 8'hff
`define MSRH_ID_BYTES 8'h02
`define MSRH_RX_DEPTH 256
`define MSRH_LEN_FIXED 9'h006
`define MSRH_LEN_ID_REQ 9'h002
`define MSRH_LEN_EXC 9'h003
`define MSRH_LEN_ECHO 9'h006
`define MSRH_LEN_ID 9'h005
`define MSRH_LEN_RD_HDR 9'h003
`define MSRH_LEN_WM_HDR 9'h007
`define MSRH_IDX_QTY 9'h004
`define MSRH_IDX_BC_SC 9'h002
`define MSRH_IDX_BC_WM 9'h006
`endif

/* File: inc/msrh_pkg.sv */
// Types shared by the request handler and its helpers.
// Assumes nothing beyond a SystemVerilog elaborator.
package msrh_pkg;
  typedef enum logic [1:0] {
    MSRH_FMT_S16,
    MSRH_FMT_U16,
    MSRH_FMT_F32,
    MSRH_FMT_OTHER
  } msrh_fmt_e;
  typedef enum logic [2:0] {
    ST_RX,
    ST_DEC,
    ST_CHK,
    ST_CHKW,
    ST_WR,
    ST_SEND,
    ST_FET
  } msrh_state_e;
endpackage

/* File: sim/msrh_map_model.sv */
// Register map model on the handler's map port: a small word store with
// unused, reserved, read-only, locked and split-value places.
// Assumes the handler samples the attributes combinationally.
`timescale 1ns/1ps
`default_nettype none
module msrh_map_model (
  input wire logic i_ref_clk,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_in_range,
  output logic o_unmapped,
  output logic o_reserved,
  output var msrh_pkg::msrh_fmt_e o_fmt,
  output logic o_ro,
  output logic o_locked,
  output logic o_mw_inner,
  output logic o_mw_open,
  output logic o_val_ok
);
  logic [15:0] mem_q [0:63];
  initial for (int i = 0; i < 64; i++) mem_q[i] = 16'h0000;
  always @(posedge i_ref_clk) if (i_wr) mem_q[i_addr[5:0]] <= i_wdata;
  always_comb begin
    o_in_range = i_addr < 16'h0040;
    o_unmapped = i_addr == 16'h0020;
    o_reserved = i_addr inside {16'h0021, 16'h0022, 16'h0023};
    o_fmt = msrh_pkg::MSRH_FMT_S16;
    if (i_addr == 16'h0021) o_fmt = msrh_pkg::MSRH_FMT_U16;
    if (i_addr[15:1] == 15'h0011) o_fmt = msrh_pkg::MSRH_FMT_F32;
    o_ro = i_addr == 16'h0024;
    o_locked = i_addr == 16'h0025;
    o_mw_inner = i_addr == 16'h0023;
    o_mw_open = i_addr == 16'h0022;
    o_val_ok = i_wdata != 16'hdead;
    // Junk unless read is strobed at a place neither unused nor reserved, so fill patterns must come from the handler
    o_rdata = (!i_rd || o_unmapped || o_reserved) ? 16'h1234 : mem_q[i_addr[5:0]];
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the request handler: frames in, answers out.
// Assumes the map model above stands on the map port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [71:0] q; int ql; logic [71:0] a; int al;} msrh_row_s;
  logic clk = 0, rst_b = 0, ser = 1, solo = 1, wra = 1, rxv = 0, rxl = 0, txr = 1, stall = 0;
  logic [7:0] uid = 8'h11, rxd = 8'h00;
  logic rdy, txv, txl, mrd, mwr, busy, inr, unm, rsv, ro, lck, inner, open, vok;
  logic [7:0] txd;
  logic [15:0] madr, mwd, mrdat;
  msrh_pkg::msrh_fmt_e fmt;
  int err_count = 0, comparisons = 0;
  msrh_row_s rows [18];
  initial forever #5 clk = ~clk;
  always @(posedge clk) txr <= #1 stall ? ~txr : 1'b1;
  msrh_req_handler #(.ID_TAG(8'h5a)) DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_is_serial(ser),
    .i_single_slave(solo), .i_unit_id(uid), .i_wr_allow(wra), .i_rx_valid(rxv),
    .i_rx_data(rxd), .i_rx_last(rxl), .o_rx_ready(rdy), .o_tx_valid(txv), .o_tx_data(txd),
    .o_tx_last(txl), .i_tx_ready(txr), .o_map_rd(mrd), .o_map_wr(mwr), .o_map_addr(madr),
    .o_map_wdata(mwd), .i_map_rdata(mrdat), .i_map_in_range(inr), .i_map_unmapped(unm),
    .i_map_reserved(rsv), .i_map_fmt(fmt), .i_map_ro(ro), .i_map_locked(lck),
    .i_map_mw_inner(inner), .i_map_mw_open(open), .i_map_val_ok(vok), .o_busy(busy));
  msrh_map_model MAP (.i_ref_clk(clk), .i_rd(mrd), .i_wr(mwr), .i_addr(madr), .i_wdata(mwd),
    .o_rdata(mrdat), .o_in_range(inr), .o_unmapped(unm), .o_reserved(rsv), .o_fmt(fmt),
    .o_ro(ro), .o_locked(lck), .o_mw_inner(inner), .o_mw_open(open), .o_val_ok(vok));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One request frame, then the answer bytes; al of 0 means silence is expected
  task automatic xact(input logic [71:0] q, input int ql, input logic [71:0] a, input int al);
    int n;
    int t;
    for (int i = 0; i < ql; i++) begin
      rxv = 1;
      rxd = q[8*(ql-1-i) +: 8];
      rxl = (i == ql - 1);
      t = 0;
      do begin @(posedge clk); t++; end while (rdy !== 1'b1 && t < 100);
      #1;
    end
    rxv = 0;
    rxl = 0;
    check("busy after frame", busy, 1'b1);
    n = 0;
    for (t = 0; t < 400; t++) begin
      @(posedge clk);
      if (txv === 1'b1 && txr === 1'b1) begin
        check("answer byte", txd, n < al ? a[8*(al-1-n) +: 8] : 8'hxx);
        check("last flag", txl, n == al - 1);
        n++;
        if (txl === 1'b1) break;
      end
      if (al == 0 && t == 60) break;
    end
    check("answer length", n, al);
    t = 0;
    while (rdy !== 1'b1 && t < 100) begin @(posedge clk); t++; end
    #1;
    check("busy when idle", busy, 1'b0);
  endtask
  initial begin
    rows = '{
      '{72'h11_0600_10be_ef, 6, 72'h11_0600_10be_ef, 6},
      '{72'h11_0300_1000_01, 6, 72'h11_0302_beef, 5},
      '{72'h11_0300_2000_01, 6, 72'h11_0302_8000, 5},
      '{72'h11_0300_2100_01, 6, 72'h11_0302_ffff, 5},
      '{72'h11_0300_2200_02, 6, 72'h11_0304_ffc0_0000, 7},
      '{72'h11_0300_2300_01, 6, 72'h11_8303, 3},
      '{72'h11_0400_1000_01, 6, 72'h11_8401, 3},
      '{72'h11_0500_1000_00, 6, 72'h11_8501, 3},
      '{72'h11_11, 2, 72'h11_1102_5aff, 5},
      '{72'h11_0600_2400_01, 6, 72'h11_8603, 3},
      '{72'h11_0600_5000_01, 6, 72'h11_8602, 3},
      '{72'h11_0600_10de_ad, 6, 72'h11_8603, 3},
      '{72'h11_0600_2500_01, 6, 72'h11_8602, 3},
      '{72'h11_6404_0010_0021, 7, 72'h11_6404_beef_ffff, 7},
      '{72'hf8_0300_1000_01, 6, 72'hf8_0302_beef, 5},
      '{72'h12_0300_1000_01, 6, 72'h0, 0},
      '{72'h00_1000_1100_0102_1234, 9, 72'h0, 0},
      '{72'h00_0600_1255_55, 6, 72'h0, 0}
    };
    #1;
    repeat (6) @(posedge clk);
    check("ready in reset", rdy, 1'b0);
    check("valid in reset", txv, 1'b0);
    #1 rst_b = 1;
    repeat (3) @(posedge clk);
    #1;
    foreach (rows[i]) xact(rows[i].q, rows[i].ql, rows[i].a, rows[i].al);
    xact(72'h11_0300_1100_01, 6, 72'h11_0302_1234, 5);
    xact(72'h11_0300_1200_01, 6, 72'h11_0302_0000, 5);
    xact(72'h11_0600_2000_01, 6, 72'h0, 0);
    xact(72'h11_1000_1300_0102_abcd, 9, 72'h11_1000_1300_01, 6);
    xact(72'h11_0300_1300_01, 6, 72'h11_0302_abcd, 5);
    xact(72'h11_0300_2200_01, 6, 72'h11_8303, 3);
    wra = 0;
    xact(72'h11_0600_1000_01, 6, 72'h11_8602, 3);
    wra = 1;
    ser = 0;
    xact(72'h11_11, 2, 72'h11_9101, 3);
    ser = 1;
    solo = 0;
    uid = 8'hf9;
    xact(72'hf9_0300_1000_01, 6, 72'h0, 0);
    xact(72'hf8_0300_1000_01, 6, 72'h0, 0);
    uid = 8'h11;
    stall = 1;
    xact(72'h11_0300_2200_02, 6, 72'h11_0304_ffc0_0000, 7);
    stall = 0;
    rst_b = 0;
    #1 check("ready in mid reset", rdy, 1'b0);
    check("valid in mid reset", txv, 1'b0);
    @(posedge clk);
    #1 rst_b = 1;
    repeat (3) @(posedge clk);
    #1;
    xact(72'h11_0300_1300_01, 6, 72'h11_0302_abcd, 5);
    test_done();
  end
  initial begin
    #200000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
